// *** logic/instr_decode_pkg.sv ***
`default_nettype none
package instr_decode_pkg;
   localparam int WORD_W = 24;
   localparam int OPC_W = 8;
   localparam int OPC_LSB = 16;
   localparam int REG_W = 4;
   localparam int MODE_W = 3;
   localparam int FILE_W = 13;
   localparam int LIT_W = 8;
   localparam int SHAMT_W = 6;
   // Operand field positions inside the low 16 bits
   localparam int F_BASE_LSB = 12;
   localparam int F_DEST_LSB = 8;
   localparam int F_SMODE_LSB = 4;
   localparam int F_SECOND_LSB = 0;
   localparam int F_BYTE_BIT = 7;
   localparam int F_FILE_FILE_OP_DEFAULT_WORKING_REG_BIT = 13;
   localparam int F_FILE_BYTE_BIT = 14;
   localparam int F_ACC_BIT = 15;
   localparam int F_MULT_LSB = 12;
   localparam int F_XPF_LSB = 8;
   localparam int F_YPF_LSB = 4;
   localparam int F_XD_LSB = 2;
   localparam int F_YD_LSB = 0;
   localparam int F_SHREG_BIT = 14;
   localparam int F_SHAMT_LSB = 8;
   // Control opcodes
   localparam logic [7:0] nop_op = 8'h00;
   localparam logic [7:0] branch_always_op = 8'h01;
   localparam logic [7:0] cond_branch_op = 8'h02;
   localparam logic [7:0] skip_op = 8'h03;
   localparam logic [7:0] call_indirect_op = 8'h04;
   localparam logic [7:0] jump_indirect_op = 8'h05;
   localparam logic [7:0] table_read_op = 8'h06;
   localparam logic [7:0] table_write_op = 8'h07;
   localparam logic [7:0] return_op = 8'h08;
   localparam logic [7:0] return_from_interrupt_op = 8'h09;
   localparam logic [7:0] dw_goto_op = 8'h0a;
   localparam logic [7:0] dw_call_op = 8'h0b;
   localparam logic [7:0] dw_loop_op = 8'h0c;
   localparam logic [7:0] move_double_op = 8'h0d;
   // Extra cycles beyond the first
   localparam logic [1:0] EXTRA_NONE = 2'h0;
   localparam logic [1:0] EXTRA_SHORT = 2'h1;
   localparam logic [1:0] EXTRA_LONG = 2'h2;
   localparam logic [7:0] EXT_PREFIX = 8'h00;

   typedef enum logic [2:0] {grp_word_byte, grp_bit, grp_literal, grp_dsp, grp_control} group_t;

   typedef struct packed {
      logic valid;
      logic [WORD_W-1:0] word;
   } fetch_t;

   typedef struct packed {
      logic valid;
      logic bad_prefix;
      logic [15:0] data;
   } ext_t;

   typedef struct packed {
      logic valid;
      logic squashed;
      logic nop;
      group_t group;
      logic [OPC_W-1:0] opcode;
      logic byte_mode;
      logic [REG_W-1:0] base_source_reg;
      logic [REG_W-1:0] second_source_reg;
      logic [MODE_W-1:0] src_mode;
      logic [REG_W-1:0] dest_reg;
      logic [MODE_W-1:0] dest_mode;
      logic file_form;
      logic [FILE_W-1:0] file_addr;
      logic to_working_reg_zero;
      logic bit_from_reg;
      logic [REG_W-1:0] bit_pos;
      logic [LIT_W-1:0] literal;
      logic acc_sel;
      logic mac;
      logic [2:0] mult_sel;
      logic [3:0] x_prefetch;
      logic [3:0] y_prefetch;
      logic [1:0] x_dest;
      logic [1:0] y_dest;
      logic [1:0] wb_dest;
      logic shift_from_reg;
      logic [REG_W-1:0] shift_count_reg;
      logic [SHAMT_W-1:0] shift_amount;
   } decoded_t;
endpackage
`default_nettype wire

// *** logic/instr_decoder.sv ***
// Contract
// - One 24-bit word per instruction: 8-bit opcode on top, operands below.
// - Exactly three opcodes use two program words; all others use one.
// - Double-word second word must have its top 8 bits zero.
// - A lone second word executes as a no-operation.
// - One cycle normally; two when a condition is true or PC changes.
// - Extra cycles are no-operations with no side effect.
// - Branch, indirect call/jump, table access, returns take two or three cycles.
// - Performed skip takes two cycles, three if skipped instruction is double-word.
// - Double-word data move takes two cycles.
// - Two-word instructions execute over two cycles, one per word.
// - Every instruction classed as word/byte, bit, literal, DSP or control.
// - Three-operand word ops: base, moded second source, moded destination.
// - File-register ops: file address, result to file or working register zero.
// - Bit ops: register or file target, bit from literal or base register.
// - Literal ops: base and literal; destination only when different.
// - MAC ops: accumulator, multiplicands, X/Y prefetch, write-back destination.
// - Other DSP ops: accumulator, moded operand, shift from register or literal.
`timescale 1ns/1ps
`default_nettype none
module instr_decoder
   import instr_decode_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Fetch side
   input wire fetch_t fetch_in,
   output logic hold_out,
   output logic flush_out,
   // Datapath side
   input wire logic cond_true_in,
   output var decoded_t dec_out,
   output var ext_t ext_out
);

   typedef enum logic [2:0] {st_run, st_ext, st_extra, st_skip, st_skip_ext} state_t;

   state_t state;
   state_t next_state;
   decoded_t next_dec;
   ext_t next_ext;
   logic next_flush;
   logic next_hold;
   logic [1:0] extra_left;
   logic [1:0] next_left;
   logic extra_pc;
   logic next_pc;
   logic skip_origin;
   logic next_skip_origin;
   logic [OPC_W-1:0] fetch_op;
   logic fetch_dw;
   logic cond_pend;
   logic taken;

   function automatic logic is_dw(input logic [OPC_W-1:0] op);
      return op == dw_goto_op || op == dw_call_op || op == dw_loop_op;
   endfunction

   function automatic logic [1:0] extra_of(input logic [OPC_W-1:0] op);
      logic [1:0] e;
      e = EXTRA_NONE;
      if (op == branch_always_op || op == call_indirect_op || op == jump_indirect_op) begin
         e = EXTRA_SHORT;
      end else if (op == table_read_op || op == table_write_op) begin
         e = EXTRA_SHORT;
      end else if (op == move_double_op) begin
         e = EXTRA_SHORT;
      end else if (op == return_op || op == return_from_interrupt_op) begin
         e = EXTRA_LONG;
      end
      return e;
   endfunction

   function automatic logic pc_chg(input logic [OPC_W-1:0] op);
      return op == branch_always_op || op == call_indirect_op || op == jump_indirect_op ||
         op == return_op || op == return_from_interrupt_op;
   endfunction

   function automatic decoded_t squash_slot();
      decoded_t d;
      d = '0;
      d.valid = 1'b1;
      d.squashed = 1'b1;
      d.nop = 1'b1;
      d.opcode = nop_op;
      d.group = grp_control;
      return d;
   endfunction

   function automatic decoded_t decode(input logic [WORD_W-1:0] w);
      decoded_t d;
      logic [OPC_W-1:0] op;
      d = '0;
      op = w[OPC_LSB +: OPC_W];
      d.valid = 1'b1;
      d.opcode = op;
      d.nop = (op == nop_op);
      d.base_source_reg = w[F_BASE_LSB +: REG_W];
      d.second_source_reg = w[F_SECOND_LSB +: REG_W];
      d.src_mode = w[F_SMODE_LSB +: MODE_W];
      d.dest_reg = w[F_DEST_LSB +: REG_W];
      d.dest_mode = op[2:0];
      unique case (op[7:5])
         3'h0: begin
            d.group = grp_control;
         end
         3'h1: begin
            d.group = grp_literal;
            d.literal = w[LIT_W-1:0];
            d.dest_mode = op[3:1];
            if (!op[0]) begin
               d.dest_reg = w[F_BASE_LSB +: REG_W];
            end
         end
         3'h2, 3'h3: begin
            d.group = grp_word_byte;
            d.byte_mode = w[F_BYTE_BIT];
         end
         3'h4: begin
            d.group = grp_word_byte;
            d.file_form = 1'b1;
            d.file_addr = w[FILE_W-1:0];
            d.to_working_reg_zero = w[F_FILE_FILE_OP_DEFAULT_WORKING_REG_BIT];
            d.byte_mode = w[F_FILE_BYTE_BIT];
         end
         3'h5: begin
            d.group = grp_bit;
            d.bit_from_reg = op[0];
            d.bit_pos = w[F_BASE_LSB +: REG_W];
            d.file_form = op[1];
            d.file_addr = w[FILE_W-1:0];
         end
         3'h6: begin
            d.group = grp_dsp;
            d.mac = 1'b1;
            d.acc_sel = w[F_ACC_BIT];
            d.mult_sel = w[F_MULT_LSB +: 3];
            d.x_prefetch = w[F_XPF_LSB +: 4];
            d.y_prefetch = w[F_YPF_LSB +: 4];
            d.x_dest = w[F_XD_LSB +: 2];
            d.y_dest = w[F_YD_LSB +: 2];
            d.wb_dest = op[1:0];
         end
         3'h7: begin
            d.group = grp_dsp;
            d.acc_sel = w[F_ACC_BIT];
            d.shift_from_reg = w[F_SHREG_BIT];
            d.shift_count_reg = w[F_DEST_LSB +: REG_W];
            d.shift_amount = w[F_SHAMT_LSB +: SHAMT_W];
         end
      endcase
      return d;
   endfunction

   assign fetch_op = fetch_in.word[OPC_LSB +: OPC_W];
   assign fetch_dw = is_dw(fetch_op);
   assign cond_pend = dec_out.valid && !dec_out.squashed &&
      (dec_out.opcode == cond_branch_op || dec_out.opcode == skip_op);
   assign taken = state == st_run && cond_pend && cond_true_in;

   always_comb begin
      next_state = state;
      next_dec = '0;
      next_ext = '0;
      next_flush = 1'b0;
      next_hold = 1'b0;
      next_left = extra_left;
      next_pc = extra_pc;
      next_skip_origin = skip_origin;
      unique case (state)
         st_run: begin
            if (taken) begin
               // Skips run on in sequence; only a branch redirects fetch
               next_flush = dec_out.opcode == cond_branch_op;
               next_skip_origin = dec_out.opcode == skip_op;
               if (fetch_in.valid) begin
                  next_dec = squash_slot();
                  if (dec_out.opcode == skip_op && fetch_dw) begin
                     next_state = st_skip_ext;
                  end
               end else if (dec_out.opcode == skip_op) begin
                  next_state = st_skip;
               end
            end else if (fetch_in.valid) begin
               next_dec = decode(fetch_in.word);
               if (fetch_dw) begin
                  next_state = st_ext;
               end else if (extra_of(fetch_op) != EXTRA_NONE) begin
                  next_state = st_extra;
                  next_left = extra_of(fetch_op) - 2'h1;
                  next_pc = pc_chg(fetch_op);
                  next_hold = !pc_chg(fetch_op);
               end
            end
         end
         st_ext: begin
            if (fetch_in.valid) begin
               next_ext.valid = 1'b1;
               next_ext.bad_prefix = fetch_in.word[OPC_LSB +: OPC_W] != EXT_PREFIX;
               next_ext.data = fetch_in.word[15:0];
               next_state = st_run;
            end
         end
         st_extra: begin
            next_dec = squash_slot();
            next_hold = !extra_pc && extra_left != 2'h0;
            // Redirect in the last inserted slot, target follows at once
            next_flush = extra_pc && extra_left == 2'h0;
            if (extra_left == 2'h0) begin
               next_state = st_run;
            end else begin
               next_left = extra_left - 2'h1;
            end
         end
         st_skip: begin
            if (fetch_in.valid) begin
               next_dec = squash_slot();
               next_state = (skip_origin && fetch_dw) ? st_skip_ext : st_run;
            end
         end
         st_skip_ext: begin
            if (fetch_in.valid) begin
               next_dec = squash_slot();
               next_state = st_run;
            end
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state <= st_run;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         extra_left <= 2'h0;
         extra_pc <= 1'b0;
         skip_origin <= 1'b0;
      end else begin
         extra_left <= next_left;
         extra_pc <= next_pc;
         skip_origin <= next_skip_origin;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         dec_out <= '0;
         ext_out <= '0;
      end else begin
         dec_out <= next_dec;
         ext_out <= next_ext;
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         flush_out <= 1'b0;
         hold_out <= 1'b0;
      end else begin
         flush_out <= next_flush;
         hold_out <= next_hold;
      end
   end

   // Checks
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   logic dec_live;
   assign dec_live = dec_out.valid && !dec_out.squashed;

   property p_nop_second;
      dec_out.valid && dec_out.opcode == nop_op |-> dec_out.nop && dec_out.group == grp_control;
   endproperty
   a_nop_second: assert property (p_nop_second) else $error("nop opcode not a nop");

   property p_ext_prefix;
      ext_out.valid |-> ext_out.bad_prefix == ($past(fetch_in.word[23:16]) != 8'h00);
   endproperty
   a_ext_prefix: assert property (p_ext_prefix) else $error("second word prefix wrong");

   property p_dw_two;
      dec_live && is_dw(dec_out.opcode) && fetch_in.valid |=> ext_out.valid && !dec_out.valid;
   endproperty
   a_dw_two: assert property (p_dw_two) else $error("second word not taken next");

   property p_single;
      dec_live && !is_dw(dec_out.opcode) && extra_of(dec_out.opcode) == 2'h0 &&
         !cond_pend |=> !dec_out.squashed;
   endproperty
   a_single: assert property (p_single) else $error("single cycle op stretched");

   property p_return_three;
      dec_live && (dec_out.opcode == return_op || dec_out.opcode == return_from_interrupt_op)
         |-> !flush_out ##1 dec_out.squashed && !flush_out ##1 dec_out.squashed && flush_out
         ##1 !dec_out.squashed;
   endproperty
   a_return_three: assert property (p_return_three) else $error("return not three cycles");

   property p_branch_two;
      dec_live && dec_out.opcode == branch_always_op |-> !flush_out ##1 dec_out.squashed &&
         flush_out ##1 !dec_out.squashed;
   endproperty
   a_branch_two: assert property (p_branch_two) else $error("branch not two cycles");

   property p_hold_two;
      dec_live && (dec_out.opcode == table_read_op || dec_out.opcode == move_double_op)
         |-> hold_out && !flush_out ##1 dec_out.squashed && !hold_out;
   endproperty
   a_hold_two: assert property (p_hold_two) else $error("table or move not two cycles");

   property p_cond_taken;
      cond_pend && cond_true_in && fetch_in.valid |=> dec_out.squashed && dec_out.nop &&
         flush_out == ($past(dec_out.opcode) == cond_branch_op);
   endproperty
   a_cond_taken: assert property (p_cond_taken) else $error("taken slot not discarded");

   property p_cond_false;
      cond_pend && !cond_true_in && fetch_in.valid |=> dec_live && !flush_out;
   endproperty
   a_cond_false: assert property (p_cond_false) else $error("untaken condition stalled");

   property p_skip_dw;
      cond_pend && cond_true_in && fetch_in.valid && dec_out.opcode == skip_op && fetch_dw
         |=> dec_out.squashed && state == st_skip_ext;
   endproperty
   a_skip_dw: assert property (p_skip_dw) else $error("double word skip too short");

   property p_squash_nop;
      dec_out.squashed |-> dec_out.nop && !ext_out.valid;
   endproperty
   a_squash_nop: assert property (p_squash_nop) else $error("discarded slot has effect");

   c_return: cover property (dec_live && dec_out.opcode == return_op ##3 dec_live);
   c_skip_dw: cover property (state == st_skip_ext ##1 dec_out.squashed);
   c_dw_ext: cover property (dec_live && is_dw(dec_out.opcode) ##1 ext_out.valid);
   c_cond: cover property (cond_pend && cond_true_in);

endmodule // instr_decoder
`default_nettype wire

// *** testbench/fetch_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module fetch_model
   import instr_decode_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // Decoder side
   input wire logic hold_in,
   input wire logic flush_in,
   output var fetch_t fetch_out
);
   logic [WORD_W-1:0] prog [0:7];
   int len = 0;
   int target = 0;
   int pc = 0;
   int at = 0;
   logic started = 1'b0;

   initial fetch_out = '0;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pc <= 0;
         started <= 1'b0;
      end else begin
         started <= 1'b1;
         if (flush_in) begin
            pc <= target + 1;
         end else if (fetch_out.valid && !hold_in) begin
            pc <= pc + 1;
         end
      end
   end

   // Flush shows the target word at once; released lines show the inverse of the last word
   always @(negedge clk_in) begin
      at = flush_in ? target : pc;
      fetch_out.valid <= started && at < len;
      fetch_out.word <= (started && at < len) ? prog[at] : ~fetch_out.word;
   end
endmodule // fetch_model
`default_nettype wire

// *** testbench/instruction_format_and_cycle_timing_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module instruction_format_and_cycle_timing_tb_top;
   import instr_decode_pkg::*;
   localparam int NREC = 24;
   logic clk_in;
   logic reset_in;
   logic cond_true_in;
   logic hold_out;
   logic flush_out;
   fetch_t fetch_in;
   decoded_t dec_out;
   ext_t ext_out;
   decoded_t dl [0:NREC-1];
   ext_t el [0:NREC-1];
   logic fl [0:NREC-1];
   logic hl [0:NREC-1];
   logic [23:0] pq [$];
   int fails = 0;
   int samples_checked = 0;

   instr_decoder dut (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .fetch_in(fetch_in),
      .hold_out(hold_out),
      .flush_out(flush_out),
      .cond_true_in(cond_true_in),
      .dec_out(dec_out),
      .ext_out(ext_out)
   );

   fetch_model fm (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .hold_in(hold_out),
      .flush_in(flush_out),
      .fetch_out(fetch_in)
   );

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Load program, reset, then record a fixed window of outputs
   task automatic run(input int tgt, input logic cnd);
      @(negedge clk_in);
      reset_in = 1'b1;
      cond_true_in = cnd;
      foreach (pq[k]) fm.prog[k] = pq[k];
      fm.len = pq.size();
      fm.target = tgt;
      repeat (8) @(negedge clk_in);
      reset_in = 1'b0;
      for (int k = 0; k < NREC; k++) begin
         @(negedge clk_in);
         dl[k] = dec_out;
         el[k] = ext_out;
         fl[k] = flush_out;
         hl[k] = hold_out;
      end
   endtask

   // First real slot at or after from; any opcode when any is set
   task automatic find(input logic [7:0] op, input logic any, input int from, output int idx);
      idx = -1;
      for (int k = NREC - 1; k >= from; k--) begin
         if (dl[k].valid === 1'b1 && dl[k].squashed === 1'b0 && (any || dl[k].opcode === op)) begin
            idx = k;
         end
      end
      if (idx < 0) begin
         fails++;
         $display("unexpected slot for opcode expected %h seen none", op);
         idx = 0;
      end
   endtask

   task automatic sq(input int i, output int n);
      n = 0;
      while (i + 1 + n < NREC && dl[i+1+n].valid === 1'b1 && dl[i+1+n].squashed === 1'b1) begin
         check("inserted slot nop", 1'b1, dl[i+1+n].nop);
         n++;
      end
   endtask

   task automatic t_groups;
      group_t eg [7] = '{grp_word_byte, grp_word_byte, grp_bit, grp_literal, grp_dsp, grp_dsp,
                         grp_control};
      int i;
      pq = '{24'h40_3a51, 24'h80_2abc, 24'ha0_7000, 24'h20_5042, 24'hc0_8000, 24'he0_0500,
             24'h00_0000};
      run(0, 1'b0);
      find(8'h40, 1'b0, 0, i);
      for (int k = 0; k < 7; k++) begin
         check("opcode", pq[k][23:16], dl[i+k].opcode);
         check("group", eg[k], dl[i+k].group);
      end
      check("base", 4'h3, dl[i].base_source_reg);
      check("second", 4'h1, dl[i].second_source_reg);
      check("dest", 4'ha, dl[i].dest_reg);
      check("file addr", 13'h0abc, dl[i+1].file_addr);
      check("to zero", 1'b1, dl[i+1].to_working_reg_zero);
      check("bit pos", 4'h7, dl[i+2].bit_pos);
      check("literal", 8'h42, dl[i+3].literal);
      check("literal dest", 4'h5, dl[i+3].dest_reg);
      check("acc", 1'b1, dl[i+4].acc_sel);
      check("shift", 6'h05, dl[i+5].shift_amount);
      $display("test groups done");
   endtask

   task automatic t_pc;
      logic [7:0] ops [8] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0d, 8'h08, 8'h09};
      int i;
      int n;
      for (int k = 0; k < 8; k++) begin
         pq = '{{ops[k], 16'h0000}, 24'h20_1000, 24'h20_2000, 24'h20_3000};
         run(1, 1'b0);
         find(ops[k], 1'b0, 0, i);
         sq(i, n);
         check("extra cycles", (k > 5) ? 2 : 1, n);
         check("flush", (k < 3 || k > 5), fl[i+n]);
         check("after pc change", 5'h11, {dl[i+1+n].valid, dl[i+1+n].base_source_reg});
         check("hold", (k > 2 && k < 6), hl[i]);
         check("second word", 1'b0, el[i+1].valid);
      end
      $display("test pc change done");
   endtask

   task automatic t_cond;
      int i;
      int j;
      int n;
      for (int c = 0; c < 2; c++) begin
         pq = '{24'h02_0000, 24'h20_1000, 24'h20_2000, 24'h20_3000};
         run(3, c[0]);
         find(8'h02, 1'b0, 0, i);
         sq(i, n);
         check("cond extra", c, n);
         find(8'h00, 1'b1, i + 1, j);
         check("after cond", (c == 1) ? 3 : 1, dl[j].base_source_reg);
      end
      $display("test cond done");
   endtask

   task automatic t_skip;
      int i;
      int j;
      int n;
      for (int d = 0; d < 2; d++) begin
         if (d == 1) begin
            pq = '{24'h03_0000, 24'h0a_0000, 24'h00_1234, 24'h20_5000};
         end else begin
            pq = '{24'h03_0000, 24'h20_1000, 24'h20_5000};
         end
         run(d + 2, 1'b1);
         find(8'h03, 1'b0, 0, i);
         sq(i, n);
         check("skip extra", d + 1, n);
         find(8'h00, 1'b1, i + 1, j);
         check("after skip", 4'h5, dl[j].base_source_reg);
      end
      $display("test skip done");
   endtask

   task automatic t_dw;
      logic [23:0] sec;
      int i;
      int j;
      for (int k = 0; k < 3; k++) begin
         sec = (k == 2) ? 24'h01_9abc : 24'h00_1234;
         pq = '{{8'h0a + 8'(k), 16'h0000}, sec, 24'h00_4321};
         run(2, 1'b0);
         find(8'h0a + 8'(k), 1'b0, 0, i);
         check("ext valid", 1'b1, el[i+1].valid);
         check("ext data", sec[15:0], el[i+1].data);
         check("bad prefix", (k == 2), el[i+1].bad_prefix);
         find(8'h00, 1'b1, i + 2, j);
         check("lone word opcode", 8'h00, dl[j].opcode);
         check("lone word nop", 1'b1, dl[j].nop);
      end
      $display("test double word done");
   endtask

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      reset_in = 1'b1;
      cond_true_in = 1'b0;
      t_groups;
      t_pc;
      t_cond;
      t_skip;
      t_dw;
      give_verdict;
   end
endmodule // instruction_format_and_cycle_timing_tb_top
`default_nettype wire
